//--- logic/boot_cfg_pkg.sv
// Shared constants, types and helpers for the strap and boot configuration link.
package boot_cfg_pkg;
   localparam logic [1:0] ROLE_PARALLEL = 2'h0;
   localparam logic [1:0] ROLE_MASTER = 2'h1;
   localparam logic [1:0] ROLE_SERIAL = 2'h3;
   localparam logic [3:0] BOOT_DISABLED = 4'hc;
   localparam int CLK_MHZ = 250;
   localparam int RESET_HOLD_NS = 1000;
   localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int REPORT_DELAY_CYCLES = 4;
   localparam int CSR_COUNT = 4;
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] POINTER_OFFSET = 8'h08;
   localparam logic [7:0] FW_DATA_OFFSET = 8'h0c;
   localparam logic [7:0] CSR_BASE_OFFSET = 8'h10;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_CLK_SEL_BIT = 1;
   localparam int CTRL_ROLE_LSB = 2;
   localparam int CTRL_BOOT_LSB = 4;
   localparam int CTRL_FW_DONE_BIT = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0014;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      DEV_RESET = 3'h0,
      DEV_BOOT = 3'h1,
      DEV_RUN = 3'h3,
      DEV_CSR = 3'h2,
      DEV_FW = 3'h6,
      DEV_CLK = 3'h7,
      DEV_REPORT = 3'h5,
      DEV_FAULT = 3'h4
   } dev_state_t;

   typedef enum logic [2:0] {
      HOST_IDLE = 3'h0,
      HOST_STRAP = 3'h1,
      HOST_HOLD = 3'h3,
      HOST_CSR = 3'h2,
      HOST_FW = 3'h6,
      HOST_CLK = 3'h7,
      HOST_WAIT = 3'h5,
      HOST_DONE = 3'h4
   } host_state_t;

   // True for boot-select codes that name a real boot source.
   function automatic logic boot_source_ok(input logic [3:0] code);
      boot_source_ok = !(code inside {4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'hf});
   endfunction
endpackage

//--- logic/strap_link_if.sv
// Strap, reset and firmware download link between host controller and codec.
interface strap_link_if (
   input wire logic aclk
);
   logic clk_sel;
   logic [1:0] host_role;
   logic [3:0] boot_sel;
   logic system_reset_low;
   logic cfg_valid;
   logic [1:0] cfg_addr;
   logic [31:0] cfg_data;
   logic fw_valid;
   logic [31:0] fw_data;
   logic clocks_enable;
   logic pointer_valid;
   logic [31:0] global_pointer_block;

   modport ctrl (
      input aclk,
      output clk_sel, host_role, boot_sel, system_reset_low,
      output cfg_valid, cfg_addr, cfg_data, fw_valid, fw_data, clocks_enable,
      input pointer_valid, global_pointer_block
   );

   modport codec (
      input aclk,
      input clk_sel, host_role, boot_sel, system_reset_low,
      input cfg_valid, cfg_addr, cfg_data, fw_valid, fw_data, clocks_enable,
      output pointer_valid, global_pointer_block
   );
endinterface

//--- logic/codec_boot_end.sv
// Codec end: strap capture, boot ROM start and slave firmware intake.
module codec_boot_end (
   // Clock and power-on reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Link to the host controller.
   strap_link_if.codec link,
   // Boot ROM control.
   output logic boot_rom_start,
   output logic [3:0] boot_source,
   output logic pll_ext_clk,
   output logic master_mode,
   output logic slave_mode,
   output logic serial_slave,
   // Video media engine control.
   output logic video_media_engine_idle,
   output logic clocks_running,
   output logic fw_we,
   output logic [15:0] fw_addr,
   output logic [31:0] fw_wdata,
   output logic [127:0] csr_bank,
   // Status.
   output logic boot_fault,
   output logic [2:0] phase
);
   boot_cfg_pkg::dev_state_t state;
   boot_cfg_pkg::dev_state_t next_state;
   logic strap_clk;
   logic next_strap_clk;
   logic [1:0] strap_role;
   logic [1:0] next_strap_role;
   logic [3:0] strap_boot;
   logic [3:0] next_strap_boot;
   logic [15:0] fw_count;
   logic [15:0] next_fw_count;
   logic [2:0] wait_count;
   logic [2:0] next_wait_count;
   logic [127:0] next_csr_bank;
   logic [3:0] csr_seen;
   logic [3:0] next_csr_seen;
   logic next_boot_rom_start;
   logic [3:0] next_boot_source;
   logic next_pll_ext_clk;
   logic next_master_mode;
   logic next_slave_mode;
   logic next_serial_slave;
   logic next_engine_idle;
   logic next_clocks_running;
   logic next_fw_we;
   logic [15:0] next_fw_addr;
   logic [31:0] next_fw_wdata;
   logic next_boot_fault;
   logic next_pointer_valid;
   logic [31:0] next_pointer;

   always_comb begin
      next_state = state;
      next_strap_clk = strap_clk;
      next_strap_role = strap_role;
      next_strap_boot = strap_boot;
      next_fw_count = fw_count;
      next_wait_count = wait_count;
      next_csr_bank = csr_bank;
      next_csr_seen = csr_seen;
      next_boot_rom_start = 1'b0;
      next_boot_source = boot_source;
      next_pll_ext_clk = pll_ext_clk;
      next_master_mode = master_mode;
      next_slave_mode = slave_mode;
      next_serial_slave = serial_slave;
      next_engine_idle = video_media_engine_idle;
      next_clocks_running = clocks_running;
      next_fw_we = 1'b0;
      next_fw_addr = fw_addr;
      next_fw_wdata = fw_wdata;
      next_boot_fault = boot_fault;
      next_pointer_valid = link.pointer_valid;
      next_pointer = link.global_pointer_block;
      if (!link.system_reset_low) begin
         // Straps track the pins while reset is low and freeze at release.
         next_strap_clk = link.clk_sel;
         next_strap_role = link.host_role;
         next_strap_boot = link.boot_sel;
         next_state = boot_cfg_pkg::DEV_RESET;
         next_fw_count = 16'h0000;
         next_wait_count = 3'h0;
         next_csr_seen = 4'h0;
         next_master_mode = 1'b0;
         next_slave_mode = 1'b0;
         next_serial_slave = 1'b0;
         next_engine_idle = 1'b1;
         next_clocks_running = 1'b0;
         next_boot_fault = 1'b0;
         next_pointer_valid = 1'b0;
         next_pointer = 32'h0000_0000;
      end else begin
         unique case (state)
            boot_cfg_pkg::DEV_RESET: begin
               next_pll_ext_clk = strap_clk;
               if (strap_role == boot_cfg_pkg::ROLE_MASTER) begin
                  next_master_mode = 1'b1;
                  next_state = boot_cfg_pkg::DEV_BOOT;
               end else if (strap_role == boot_cfg_pkg::ROLE_PARALLEL ||
                            strap_role == boot_cfg_pkg::ROLE_SERIAL) begin
                  next_slave_mode = 1'b1;
                  next_serial_slave = strap_role == boot_cfg_pkg::ROLE_SERIAL;
                  next_state = boot_cfg_pkg::DEV_CSR;
               end else begin
                  next_boot_fault = 1'b1;
                  next_state = boot_cfg_pkg::DEV_FAULT;
               end
            end
            boot_cfg_pkg::DEV_BOOT: begin
               // The boot ROM is started from the captured clock and boot straps.
               next_boot_source = strap_boot;
               if (boot_cfg_pkg::boot_source_ok(strap_boot)) begin
                  next_boot_rom_start = 1'b1;
                  next_engine_idle = 1'b0;
                  next_state = boot_cfg_pkg::DEV_RUN;
               end else begin
                  next_boot_fault = 1'b1;
                  next_state = boot_cfg_pkg::DEV_FAULT;
               end
            end
            boot_cfg_pkg::DEV_RUN: begin
               next_state = boot_cfg_pkg::DEV_RUN;
            end
            boot_cfg_pkg::DEV_CSR: begin
               next_engine_idle = 1'b1;
               if (link.cfg_valid) begin
                  next_csr_bank[link.cfg_addr * 32 +: 32] = link.cfg_data;
                  next_csr_seen[link.cfg_addr] = 1'b1;
               end
               if (link.fw_valid || link.clocks_enable) begin
                  // Firmware before any register write, or clocks at any point in this state, is out of order.
                  if (csr_seen == 4'h0 || link.clocks_enable) begin
                     next_boot_fault = 1'b1;
                     next_state = boot_cfg_pkg::DEV_FAULT;
                  end else begin
                     next_fw_we = 1'b1;
                     next_fw_addr = fw_count;
                     next_fw_wdata = link.fw_data;
                     next_fw_count = fw_count + 16'h0001;
                     next_state = boot_cfg_pkg::DEV_FW;
                  end
               end
            end
            boot_cfg_pkg::DEV_FW: begin
               if (link.cfg_valid) begin
                  next_boot_fault = 1'b1;
                  next_state = boot_cfg_pkg::DEV_FAULT;
               end else if (link.fw_valid) begin
                  next_fw_we = 1'b1;
                  next_fw_addr = fw_count;
                  next_fw_wdata = link.fw_data;
                  next_fw_count = fw_count + 16'h0001;
               end else if (link.clocks_enable) begin
                  next_clocks_running = 1'b1;
                  next_state = boot_cfg_pkg::DEV_CLK;
               end
            end
            boot_cfg_pkg::DEV_CLK: begin
               next_wait_count = wait_count + 3'h1;
               if (wait_count == 3'(boot_cfg_pkg::REPORT_DELAY_CYCLES - 1)) begin
                  // The pointer block sits just past the loaded image.
                  next_pointer = csr_bank[31:0] + {14'h0, fw_count, 2'h0};
                  next_pointer_valid = 1'b1;
                  next_engine_idle = 1'b0;
                  next_state = boot_cfg_pkg::DEV_REPORT;
               end
            end
            boot_cfg_pkg::DEV_REPORT: begin
               next_pointer_valid = 1'b1;
            end
            boot_cfg_pkg::DEV_FAULT: begin
               next_boot_fault = 1'b1;
            end
            default: begin
               next_state = boot_cfg_pkg::DEV_FAULT;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= boot_cfg_pkg::DEV_RESET;
         strap_clk <= 1'b0;
         strap_role <= boot_cfg_pkg::ROLE_PARALLEL;
         strap_boot <= boot_cfg_pkg::BOOT_DISABLED;
         fw_count <= 16'h0000;
         wait_count <= 3'h0;
         csr_bank <= 128'h0;
         csr_seen <= 4'h0;
         boot_rom_start <= 1'b0;
         boot_source <= boot_cfg_pkg::BOOT_DISABLED;
         pll_ext_clk <= 1'b0;
         master_mode <= 1'b0;
         slave_mode <= 1'b0;
         serial_slave <= 1'b0;
         video_media_engine_idle <= 1'b1;
         clocks_running <= 1'b0;
         fw_we <= 1'b0;
         fw_addr <= 16'h0000;
         fw_wdata <= 32'h0000_0000;
         boot_fault <= 1'b0;
         link.pointer_valid <= 1'b0;
         link.global_pointer_block <= 32'h0000_0000;
      end else begin
         state <= next_state;
         strap_clk <= next_strap_clk;
         strap_role <= next_strap_role;
         strap_boot <= next_strap_boot;
         fw_count <= next_fw_count;
         wait_count <= next_wait_count;
         csr_bank <= next_csr_bank;
         csr_seen <= next_csr_seen;
         boot_rom_start <= next_boot_rom_start;
         boot_source <= next_boot_source;
         pll_ext_clk <= next_pll_ext_clk;
         master_mode <= next_master_mode;
         slave_mode <= next_slave_mode;
         serial_slave <= next_serial_slave;
         video_media_engine_idle <= next_engine_idle;
         clocks_running <= next_clocks_running;
         fw_we <= next_fw_we;
         fw_addr <= next_fw_addr;
         fw_wdata <= next_fw_wdata;
         boot_fault <= next_boot_fault;
         link.pointer_valid <= next_pointer_valid;
         link.global_pointer_block <= next_pointer;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 3'h0;
      end else begin
         phase <= next_state;
      end
   end
endmodule

//--- logic/host_boot_ctrl.sv
// Host end: AXI4-Lite controlled strap, reset and firmware download sequencer.
module host_boot_ctrl (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link to the codec.
   strap_link_if.ctrl link
);
   boot_cfg_pkg::host_state_t state;
   boot_cfg_pkg::host_state_t next_state;
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [127:0] csr_store;
   logic [127:0] next_csr_store;
   logic [31:0] pointer;
   logic [31:0] next_pointer;
   logic [8:0] count;
   logic [8:0] next_count;
   logic [7:0] awaddr;
   logic [7:0] next_awaddr;
   logic [31:0] wdata;
   logic [31:0] next_wdata;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic wr_fire;
   logic next_clk_sel;
   logic [1:0] next_role;
   logic [3:0] next_boot;
   logic next_reset_low;
   logic next_cfg_valid;
   logic [1:0] next_cfg_addr;
   logic [31:0] next_cfg_data;
   logic next_fw_valid;
   logic [31:0] next_fw_data;
   logic next_clocks_enable;

   always_comb begin
      next_awready = s_axi_awready;
      next_wready = s_axi_wready;
      next_awaddr = awaddr;
      next_wdata = wdata;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_arready = 1'b1;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      wr_fire = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_awaddr = s_axi_awaddr;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wdata = s_axi_wdata;
         next_wready = 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
         wr_fire = 1'b1;
         next_bvalid = 1'b1;
         next_bresp = boot_cfg_pkg::RESP_OKAY;
         if (awaddr == boot_cfg_pkg::FW_DATA_OFFSET && state != boot_cfg_pkg::HOST_FW) begin
            next_bresp = boot_cfg_pkg::RESP_SLVERR;
         end else if (awaddr > boot_cfg_pkg::CSR_BASE_OFFSET + 8'h0c ||
                      awaddr == boot_cfg_pkg::STATUS_OFFSET ||
                      awaddr == boot_cfg_pkg::POINTER_OFFSET) begin
            next_bresp = boot_cfg_pkg::RESP_SLVERR;
         end
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end
      if (s_axi_rvalid) begin
         next_arready = 1'b0;
         if (s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = boot_cfg_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            boot_cfg_pkg::CTRL_OFFSET: next_rdata = ctrl;
            boot_cfg_pkg::STATUS_OFFSET: next_rdata = {27'h0, link.pointer_valid,
               state == boot_cfg_pkg::HOST_DONE, state};
            boot_cfg_pkg::POINTER_OFFSET: next_rdata = pointer;
            boot_cfg_pkg::CSR_BASE_OFFSET: next_rdata = csr_store[31:0];
            boot_cfg_pkg::CSR_BASE_OFFSET + 8'h04: next_rdata = csr_store[63:32];
            boot_cfg_pkg::CSR_BASE_OFFSET + 8'h08: next_rdata = csr_store[95:64];
            boot_cfg_pkg::CSR_BASE_OFFSET + 8'h0c: next_rdata = csr_store[127:96];
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = boot_cfg_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_csr_store = csr_store;
      next_pointer = pointer;
      next_count = count;
      next_clk_sel = link.clk_sel;
      next_role = link.host_role;
      next_boot = link.boot_sel;
      next_reset_low = link.system_reset_low;
      next_cfg_valid = 1'b0;
      next_cfg_addr = link.cfg_addr;
      next_cfg_data = link.cfg_data;
      next_fw_valid = 1'b0;
      next_fw_data = link.fw_data;
      next_clocks_enable = link.clocks_enable;
      if (wr_fire && next_bresp == boot_cfg_pkg::RESP_OKAY) begin
         if (awaddr == boot_cfg_pkg::CTRL_OFFSET) begin
            next_ctrl = wdata;
         end else if (awaddr == boot_cfg_pkg::FW_DATA_OFFSET) begin
            next_fw_valid = 1'b1;
            next_fw_data = wdata;
         end else begin
            next_csr_store[awaddr[3:2] * 32 +: 32] = wdata;
         end
      end
      unique case (state)
         boot_cfg_pkg::HOST_IDLE, boot_cfg_pkg::HOST_DONE: begin
            if (next_ctrl[boot_cfg_pkg::CTRL_START_BIT]) begin
               next_ctrl[boot_cfg_pkg::CTRL_START_BIT] = 1'b0;
               next_ctrl[boot_cfg_pkg::CTRL_FW_DONE_BIT] = 1'b0;
               next_reset_low = 1'b0;
               next_clocks_enable = 1'b0;
               next_clk_sel = next_ctrl[boot_cfg_pkg::CTRL_CLK_SEL_BIT];
               next_role = next_ctrl[boot_cfg_pkg::CTRL_ROLE_LSB +: 2];
               next_boot = next_ctrl[boot_cfg_pkg::CTRL_BOOT_LSB +: 4];
               if (next_role != boot_cfg_pkg::ROLE_MASTER) begin
                  next_boot = boot_cfg_pkg::BOOT_DISABLED;
               end
               next_state = boot_cfg_pkg::HOST_STRAP;
            end
         end
         boot_cfg_pkg::HOST_STRAP: begin
            next_count = 9'h000;
            next_state = boot_cfg_pkg::HOST_HOLD;
         end
         boot_cfg_pkg::HOST_HOLD: begin
            next_count = count + 9'h001;
            if (count == 9'(boot_cfg_pkg::RESET_HOLD_CYCLES - 1)) begin
               next_reset_low = 1'b1;
               next_count = 9'h000;
               next_state = link.host_role == boot_cfg_pkg::ROLE_MASTER ?
                  boot_cfg_pkg::HOST_DONE : boot_cfg_pkg::HOST_CSR;
            end
         end
         boot_cfg_pkg::HOST_CSR: begin
            next_cfg_valid = 1'b1;
            next_cfg_addr = count[1:0];
            next_cfg_data = csr_store[count[1:0] * 32 +: 32];
            next_count = count + 9'h001;
            if (count == 9'(boot_cfg_pkg::CSR_COUNT - 1)) begin
               next_state = boot_cfg_pkg::HOST_FW;
            end
         end
         boot_cfg_pkg::HOST_FW: begin
            if (ctrl[boot_cfg_pkg::CTRL_FW_DONE_BIT] && !next_fw_valid && !link.fw_valid) begin
               next_state = boot_cfg_pkg::HOST_CLK;
            end
         end
         boot_cfg_pkg::HOST_CLK: begin
            next_clocks_enable = 1'b1;
            next_state = boot_cfg_pkg::HOST_WAIT;
         end
         boot_cfg_pkg::HOST_WAIT: begin
            if (link.pointer_valid) begin
               next_pointer = link.global_pointer_block;
               next_state = boot_cfg_pkg::HOST_DONE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awaddr <= 8'h00;
         wdata <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= boot_cfg_pkg::RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= boot_cfg_pkg::RESP_OKAY;
         state <= boot_cfg_pkg::HOST_IDLE;
         ctrl <= boot_cfg_pkg::CTRL_RESET;
         csr_store <= 128'h0;
         pointer <= 32'h0000_0000;
         count <= 9'h000;
         link.clk_sel <= 1'b0;
         link.host_role <= boot_cfg_pkg::ROLE_MASTER;
         link.boot_sel <= boot_cfg_pkg::BOOT_DISABLED;
         link.system_reset_low <= 1'b0;
         link.cfg_valid <= 1'b0;
         link.cfg_addr <= 2'h0;
         link.cfg_data <= 32'h0000_0000;
         link.fw_valid <= 1'b0;
         link.fw_data <= 32'h0000_0000;
         link.clocks_enable <= 1'b0;
      end else begin
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         awaddr <= next_awaddr;
         wdata <= next_wdata;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         state <= next_state;
         ctrl <= next_ctrl;
         csr_store <= next_csr_store;
         pointer <= next_pointer;
         count <= next_count;
         link.clk_sel <= next_clk_sel;
         link.host_role <= next_role;
         link.boot_sel <= next_boot;
         link.system_reset_low <= next_reset_low;
         link.cfg_valid <= next_cfg_valid;
         link.cfg_addr <= next_cfg_addr;
         link.cfg_data <= next_cfg_data;
         link.fw_valid <= next_fw_valid;
         link.fw_data <= next_fw_data;
         link.clocks_enable <= next_clocks_enable;
      end
   end
endmodule

//--- test/boot_link_chk.sv
// Assertions on the strap link between the host and codec ends.
module boot_link_chk (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Link signals.
   input wire logic clk_sel,
   input wire logic [1:0] host_role,
   input wire logic [3:0] boot_sel,
   input wire logic system_reset_low,
   input wire logic cfg_valid,
   input wire logic [1:0] cfg_addr,
   input wire logic [31:0] cfg_data,
   input wire logic fw_valid,
   input wire logic clocks_enable,
   input wire logic pointer_valid,
   input wire logic [31:0] global_pointer_block
);
   logic [8:0] low_cnt;
   logic [2:0] cfg_cnt;
   logic [31:0] base, words;
   wire logic [6:0] straps = {clk_sel, host_role, boot_sel};
   always_ff @(posedge aclk) begin
      if (!aresetn || system_reset_low) low_cnt <= 9'h0;
      else if (low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h1;
      if (!aresetn || !system_reset_low) begin
         cfg_cnt <= 3'h0;
         words <= 32'h0;
      end else begin
         cfg_cnt <= cfg_cnt + {2'h0, cfg_valid};
         words <= words + {31'h0, fw_valid};
      end
      if (cfg_valid && cfg_addr == 2'h0) base <= cfg_data;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_hold: assert property ($rose(system_reset_low) |->
      low_cnt >= boot_cfg_pkg::RESET_HOLD_CYCLES) else $error("reset hold short");
   a_straps_set: assert property ($rose(system_reset_low) |-> $stable(straps))
      else $error("straps late");
   a_slave_bootoff: assert property (system_reset_low && host_role inside {2'h0, 2'h3}
      |-> boot_sel == 4'hc) else $error("slave boot code");
   a_master_alone: assert property (system_reset_low && host_role == 2'h1
      |-> !(cfg_valid || fw_valid || clocks_enable)) else $error("master disturbed");
   a_cfg_order: assert property (cfg_valid |-> cfg_addr == cfg_cnt[1:0] && words == 0)
      else $error("cfg order");
   a_fw_after_cfg: assert property (fw_valid || $rose(clocks_enable) |-> cfg_cnt == 3'h4)
      else $error("fw before cfg");
   a_ptr_delay: assert property ($rose(clocks_enable) |->
      !pointer_valid [*4] ##[1:2] pointer_valid) else $error("pointer delay");
   a_ptr_value: assert property ($rose(pointer_valid) |->
      global_pointer_block == base + (words << 2)) else $error("pointer value");
   a_ptr_held: assert property (pointer_valid && system_reset_low |=> pointer_valid)
      else $error("pointer dropped");
   cover property ($rose(pointer_valid));
   cover property ($rose(system_reset_low) && host_role == 2'h1);
   cover property (cfg_valid && cfg_addr == 2'h3);
endmodule

//--- test/tb_top.sv
// Bench joining the host and codec ends over the strap link.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic boot_rom_start, pll_ext_clk, master_mode, slave_mode, serial_slave, boot_fault;
   logic video_media_engine_idle, clocks_running;
   logic [3:0] boot_source;
   logic [127:0] csr_bank;
   int failures = 0, tests_run = 0;
   always #2 aclk = ~aclk;
   strap_link_if link (.aclk(aclk));
   host_boot_ctrl host_boot_ctrl_inst (.*);
   codec_boot_end codec_boot_end_inst (.*, .fw_we(), .fw_addr(),
      .fw_wdata(), .phase());
   boot_link_chk boot_link_chk_inst (.aclk, .aresetn, .clk_sel(link.clk_sel),
      .host_role(link.host_role), .boot_sel(link.boot_sel), .cfg_data(link.cfg_data),
      .system_reset_low(link.system_reset_low), .cfg_valid(link.cfg_valid),
      .cfg_addr(link.cfg_addr), .fw_valid(link.fw_valid), .clocks_enable(link.clocks_enable),
      .pointer_valid(link.pointer_valid), .global_pointer_block(link.global_pointer_block));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic refusals;
      rd(8'h00);
      `CHK({resp, rdat}, {boot_cfg_pkg::RESP_OKAY, boot_cfg_pkg::CTRL_RESET})
      wr(8'h04, 32'h1);
      `CHK(resp, boot_cfg_pkg::RESP_SLVERR)
      wr(8'h0c, 32'h1);
      `CHK(resp, boot_cfg_pkg::RESP_SLVERR)
      rd(8'h20);
      `CHK({resp, rdat}, {boot_cfg_pkg::RESP_SLVERR, 32'h0})
      $display("register refusals done");
   endtask
   task automatic master_boot(input logic [3:0] b, input logic bad);
      int i;
      wr(8'h00, {24'h0, b, 4'h7});
      repeat (4) @(posedge aclk);
      for (i = 0; i < 400 && !boot_rom_start && !boot_fault; i++) @(posedge aclk);
      `CHK({boot_rom_start, boot_fault}, {!bad, bad})
      `CHK({boot_source, master_mode, pll_ext_clk}, {b, 2'h3})
      $display("master boot %h done", b);
   endtask
   task automatic slave_boot(input logic [1:0] role);
      int i;
      for (i = 0; i < 4; i++) wr(8'h10 + 8'(4 * i), 32'h100 * (i + 1));
      wr(8'h00, {28'h0, role, 2'h1});
      repeat (4) @(posedge aclk);
      for (i = 0; i < 400 && !link.system_reset_low; i++) @(posedge aclk);
      repeat (8) @(posedge aclk);
      `CHK({slave_mode, serial_slave, video_media_engine_idle}, {1'b1, role[1], 1'b1})
      `CHK({link.boot_sel, pll_ext_clk, csr_bank[31:0]}, {4'hc, 1'b0, 32'h100})
      for (i = 0; i < 3; i++) wr(8'h0c, 32'(i));
      `CHK(resp, boot_cfg_pkg::RESP_OKAY)
      wr(8'h00, {23'h0, 1'b1, 4'h0, role, 2'h0});
      for (i = 0; i < 40 && !link.pointer_valid; i++) @(posedge aclk);
      rd(8'h08);
      `CHK({link.pointer_valid, clocks_running, rdat}, {2'h3, 32'h10c})
      rd(8'h04);
      `CHK(rdat, 32'h0000_001c)
      $display("slave boot role %0d done", role);
   endtask
   task automatic end_of_test;
      $display("tests_run %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Five boots of under 400 cycles each fit well inside this span.
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      refusals();
      master_boot(4'h9, 1'b0);
      master_boot(4'hc, 1'b1);
      slave_boot(2'h0);
      master_boot(4'h0, 1'b0);
      slave_boot(2'h3);
      end_of_test();
   end
endmodule
